// ---- shared/ufhis_defines.svh ----
// Register offsets, bit positions, reset values and counts of the halt and interrupt status block.
`ifndef UFHIS_DEFINES_SVH
`define UFHIS_DEFINES_SVH

`define UFHIS_A_SRC_BUS      32'h0ffffe10
`define UFHIS_A_SRC_CTRL     32'hfffffe11
`define UFHIS_A_EP_STAT0     32'h0ffffe07
`define UFHIS_A_EP_STAT1     32'hfffffe08
`define UFHIS_A_HALT_FLAGS   32'hfffffe09
`define UFHIS_A_HALT_SET     32'hfffffe0a
`define UFHIS_A_HALT_CLR     32'hfffffe0b
`define UFHIS_A_CLR_BUS      32'hfffffe0c
`define UFHIS_A_CLR_CTRL     32'hfffffe0d
`define UFHIS_A_DMA_EN       32'hfffffe0e
`define UFHIS_A_DMA_DONE     32'hfffffe0f
`define UFHIS_A_SETUP_BUF    32'hfffffe20

`define UFHIS_B_BUS_RESET    7
`define UFHIS_B_RES_SUSP     6
`define UFHIS_B_SHORT        4
`define UFHIS_B_DMA_END      3
`define UFHIS_B_SET_DONE     2
`define UFHIS_B_CLR_DONE     1
`define UFHIS_B_EP_STALL     0
`define UFHIS_B_IN_NAK       6
`define UFHIS_B_TX_DONE      5
`define UFHIS_B_RX_DONE      4
`define UFHIS_B_STAT_OK      3
`define UFHIS_B_STAT_PHASE   2
`define UFHIS_B_SETUP_SEEN   1
`define UFHIS_B_FW_DECODE    0
`define UFHIS_B_SUSPENDED    7

`define UFHIS_RST_BYTE       8'h00
`define UFHIS_SETUP_LAST     3'h7

`endif

// ---- shared/ufhis_pkg.sv ----
// Types shared by the halt and interrupt status block.
package ufhis_pkg;
    typedef logic [7:0] ufhis_byte_t;
    typedef logic [6:0] ufhis_ep_t;
    typedef enum logic [3:0] {
        UFHIS_REQ_GET_STATUS_EP0,
        UFHIS_REQ_CLEAR_FEATURE_EP,
        UFHIS_REQ_CLEAR_FEATURE_DEV,
        UFHIS_REQ_SET_FEATURE_EP,
        UFHIS_REQ_SET_FEATURE_DEV,
        UFHIS_REQ_SET_ADDRESS,
        UFHIS_REQ_SET_CONFIG,
        UFHIS_REQ_SET_INTERFACE,
        UFHIS_REQ_FW_DECODE
    } ufhis_req_t;
endpackage

// ---- shared/ufhis_flag_if.sv ----
// Set, clear and state lines of a group of sticky flags.
interface ufhis_flag_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport owner (input set, input clr, output q);
    modport user  (output set, output clr, input q);
endinterface

// ---- design/ufhis_sync.sv ----
// Two-flop synchroniser for inputs that arrive from pins.
module ufhis_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] INI = '0
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= INI;
            q    <= INI;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ---- design/ufhis_flags.sv ----
// Group of sticky flags in which a set beats a clear in the same cycle.
module ufhis_flags #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Flag group
    ufhis_flag_if.owner fl
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fl.q <= '0;
        end else begin
            fl.q <= (fl.q & ~fl.clr) | fl.set;
        end
    end

    // Hardware events must never be lost to a clear arriving in the same cycle.
    a_set_beats_clr: assert property (@(posedge mclk) disable iff (rst)
        (fl.set != '0) |=> ((fl.q & $past(fl.set)) == $past(fl.set)))
        else $error("flag set lost to a clear");
endmodule

// ---- design/ufhis_status.sv ----
// Endpoint halt status and the two interrupt source registers of the USB function unit.
//
// Our own choice: the strobed register port.
`include "ufhis_defines.svh"

module ufhis_status #(
    parameter int DMA_EPS = 6
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Register port
    input  wire logic [31:0]           addr,
    input  wire ufhis_pkg::ufhis_byte_t wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output ufhis_pkg::ufhis_byte_t     rdata,
    // Bus and endpoint events from the serial engine
    input  wire logic                  bus_reset_det,
    input  wire logic                  resume_suspend_evt,
    input  wire logic                  bus_suspended,
    input  wire logic                  setup_token,
    input  wire logic                  setup_stored,
    input  wire logic [63:0]           setup_packet_buffer,
    input  wire ufhis_pkg::ufhis_ep_t  stall_ep,
    // Request decode results
    input  wire logic                  req_valid,
    input  wire ufhis_pkg::ufhis_req_t req_kind,
    input  wire logic [2:0]            req_ep,
    input  wire ufhis_pkg::ufhis_ep_t  req_targets,
    // Endpoint 0 transfer events
    input  wire logic                  in_nak_ep0,
    input  wire logic                  tx_ack_ep0,
    input  wire logic                  rx_data_ep0,
    input  wire logic                  status_done,
    input  wire logic                  status_enter,
    input  wire logic                  status_enter_no_ack,
    input  wire logic                  fw_read_xfer,
    input  wire logic                  ctrl_tx_fifo_write,
    input  wire logic                  ctrl_tx_fifo_cleared,
    input  wire logic                  ctrl_rx_drained,
    // Bulk-out and DMA
    input  wire logic [1:0]            bulk_read,
    input  wire logic [1:0]            bulk_dma_full,
    input  wire logic [1:0]            short_packet_signal_n,
    input  wire logic [DMA_EPS-1:0]    dma_tc_n,
    input  wire logic [DMA_EPS-1:0]    dma_fifo_ready,
    output logic      [DMA_EPS-1:0]    dma_req,
    // Status outputs
    output logic                       usb_irq_line_a_n,
    output ufhis_pkg::ufhis_ep_t       endpoint_halt_flags,
    output logic                       send_stall_flag,
    output logic                       stall_handshake,
    output logic                       ctrl_tx_arm_clear,
    output logic                       ctrl_rx_present
);
    import ufhis_pkg::*;

    function automatic ufhis_ep_t ep_onehot(input logic [2:0] idx);
        ep_onehot = ufhis_ep_t'(7'h01 << idx);
    endfunction

    function automatic logic is_req(input logic v, input ufhis_req_t k, input ufhis_req_t w);
        is_req = v && (k == w);
    endfunction

    // Address decode.
    wire logic sel_src_bus  = (addr == `UFHIS_A_SRC_BUS);
    wire logic sel_src_ctrl = (addr == `UFHIS_A_SRC_CTRL);
    wire logic sel_stat0    = (addr == `UFHIS_A_EP_STAT0);
    wire logic sel_stat1    = (addr == `UFHIS_A_EP_STAT1);
    wire logic sel_halt     = (addr == `UFHIS_A_HALT_FLAGS);
    wire logic sel_halt_set = (addr == `UFHIS_A_HALT_SET);
    wire logic sel_halt_clr = (addr == `UFHIS_A_HALT_CLR);
    wire logic sel_clr_bus  = (addr == `UFHIS_A_CLR_BUS);
    wire logic sel_clr_ctrl = (addr == `UFHIS_A_CLR_CTRL);
    wire logic sel_dma_en   = (addr == `UFHIS_A_DMA_EN);
    wire logic sel_dma_done = (addr == `UFHIS_A_DMA_DONE);
    wire logic sel_setup    = (addr == `UFHIS_A_SETUP_BUF);

    wire logic wr_halt_set = wr && sel_halt_set;
    wire logic wr_halt_clr = wr && sel_halt_clr;
    wire logic wr_clr_bus  = wr && sel_clr_bus;
    wire logic wr_clr_ctrl = wr && sel_clr_ctrl;
    wire logic wr_dma_en   = wr && sel_dma_en;
    wire logic rd_stat1    = rd && sel_stat1;
    wire logic rd_dma_done = rd && sel_dma_done;
    wire logic rd_setup    = rd && sel_setup;

    // Pin inputs pass two flops before any logic looks at them.
    logic [1:0]         short_s_n;
    logic [DMA_EPS-1:0] tc_s_n;
    logic [DMA_EPS-1:0] tc_prev_n;

    ufhis_sync #(.W(2), .INI(2'h3)) u_sync_short (
        .mclk (mclk),
        .rst  (rst),
        .d    (short_packet_signal_n),
        .q    (short_s_n)
    );

    ufhis_sync #(.W(DMA_EPS), .INI({DMA_EPS{1'b1}})) u_sync_tc (
        .mclk (mclk),
        .rst  (rst),
        .d    (dma_tc_n),
        .q    (tc_s_n)
    );

    wire logic [DMA_EPS-1:0] tc_edge = tc_prev_n & ~tc_s_n;

    // Request decode.
    wire logic       rq_get0     = is_req(req_valid, req_kind, UFHIS_REQ_GET_STATUS_EP0);
    wire logic       rq_clr_ep   = is_req(req_valid, req_kind, UFHIS_REQ_CLEAR_FEATURE_EP);
    wire logic       rq_clr_dev  = is_req(req_valid, req_kind, UFHIS_REQ_CLEAR_FEATURE_DEV);
    wire logic       rq_set_ep   = is_req(req_valid, req_kind, UFHIS_REQ_SET_FEATURE_EP);
    wire logic       rq_set_dev  = is_req(req_valid, req_kind, UFHIS_REQ_SET_FEATURE_DEV);
    wire logic       rq_set_addr = is_req(req_valid, req_kind, UFHIS_REQ_SET_ADDRESS);
    wire logic       rq_fw_dec   = is_req(req_valid, req_kind, UFHIS_REQ_FW_DECODE);
    wire logic       rq_reconf   = is_req(req_valid, req_kind, UFHIS_REQ_SET_CONFIG) ||
                                   is_req(req_valid, req_kind, UFHIS_REQ_SET_INTERFACE);
    wire logic       rq_cfg_only = is_req(req_valid, req_kind, UFHIS_REQ_SET_CONFIG);
    wire ufhis_ep_t  rq_ep_hot   = ep_onehot(req_ep);

    // Halt state: condition stalls, halt features, endpoint 0 read mask.
    ufhis_ep_t halt_cond;
    ufhis_ep_t halt_feat;
    logic      ep0_mask;

    wire logic ep0_halted_raw = halt_cond[0] | halt_feat[0];
    // A reconfiguration arriving while endpoint 0 is halted is refused, so it clears nothing.
    wire logic reconf_ok      = rq_reconf && !ep0_halted_raw;
    wire logic reconf_stalled = rq_reconf && ep0_halted_raw;

    wire ufhis_ep_t feat_set = (rq_set_ep ? rq_ep_hot : 7'h00) |
                               (wr_halt_set ? wdata[6:0] : 7'h00);
    wire ufhis_ep_t feat_clr = (rq_clr_ep ? rq_ep_hot : 7'h00) |
                               (wr_halt_clr ? wdata[6:0] : 7'h00) |
                               (reconf_ok ? {req_targets[6:1], 1'b0} : 7'h00);
    wire ufhis_ep_t cond_clr = {feat_clr[6:1], setup_token};

    wire ufhis_ep_t next_halt_cond = (halt_cond & ~cond_clr) | stall_ep;
    wire ufhis_ep_t next_halt_feat = (halt_feat & ~feat_clr) | feat_set;
    wire logic      mask_set       = rq_get0 || rq_fw_dec ||
                                     ((rq_clr_ep || rq_set_ep) && req_ep == 3'h0);
    wire logic      next_ep0_mask  = (ep0_mask && !setup_token) || mask_set;
    wire logic      next_snd_stall = (send_stall_flag && !setup_token) || stall_ep[0];
    wire ufhis_ep_t next_halted    = (next_halt_cond | next_halt_feat) &
                                     ~{6'h00, next_ep0_mask};

    // Source register events.
    ufhis_flag_if #(.W(8)) src_bus ();
    ufhis_flag_if #(.W(8)) src_ctrl ();

    wire logic short_evt = |(bulk_read & bulk_dma_full & ~short_s_n);
    wire logic stall_evt = (stall_ep != 7'h00) || rq_set_ep || wr_halt_set;

    always_comb begin
        src_bus.set                      = 8'h00;
        src_bus.set[`UFHIS_B_BUS_RESET]  = bus_reset_det;
        src_bus.set[`UFHIS_B_RES_SUSP]   = resume_suspend_evt;
        src_bus.set[`UFHIS_B_SHORT]      = short_evt;
        src_bus.set[`UFHIS_B_DMA_END]    = |tc_edge;
        src_bus.set[`UFHIS_B_SET_DONE]   = rq_set_addr || rq_set_ep || rq_set_dev ||
                                           (rq_cfg_only && reconf_ok);
        src_bus.set[`UFHIS_B_CLR_DONE]   = rq_clr_ep || rq_clr_dev;
        src_bus.set[`UFHIS_B_EP_STALL]   = stall_evt;
    end

    // Software writing zero is the only way to clear the first register.
    assign src_bus.clr = wr_clr_bus ? ~wdata : 8'h00;

    logic [2:0] setup_cnt;
    wire logic  setup_last = rd_setup && (setup_cnt == `UFHIS_SETUP_LAST);

    always_comb begin
        src_ctrl.set                      = 8'h00;
        src_ctrl.set[`UFHIS_B_IN_NAK]     = in_nak_ep0;
        src_ctrl.set[`UFHIS_B_TX_DONE]    = tx_ack_ep0;
        src_ctrl.set[`UFHIS_B_RX_DONE]    = rx_data_ep0;
        src_ctrl.set[`UFHIS_B_STAT_OK]    = status_done;
        src_ctrl.set[`UFHIS_B_STAT_PHASE] = status_enter || status_enter_no_ack;
        src_ctrl.set[`UFHIS_B_SETUP_SEEN] = setup_stored;
        src_ctrl.set[`UFHIS_B_FW_DECODE]  = rq_fw_dec;
    end

    always_comb begin
        src_ctrl.clr                      = wr_clr_ctrl ? ~wdata : 8'h00;
        src_ctrl.clr[`UFHIS_B_TX_DONE]    = src_ctrl.clr[`UFHIS_B_TX_DONE] ||
                                            ctrl_tx_fifo_write;
        src_ctrl.clr[`UFHIS_B_RX_DONE]    = src_ctrl.clr[`UFHIS_B_RX_DONE] ||
                                            ctrl_rx_drained;
        src_ctrl.clr[`UFHIS_B_STAT_OK]    = src_ctrl.clr[`UFHIS_B_STAT_OK] ||
                                            setup_token;
        src_ctrl.clr[`UFHIS_B_STAT_PHASE] = src_ctrl.clr[`UFHIS_B_STAT_PHASE] ||
                                            setup_token;
        src_ctrl.clr[`UFHIS_B_FW_DECODE]  = src_ctrl.clr[`UFHIS_B_FW_DECODE] ||
                                            setup_last;
    end

    ufhis_flags #(.W(8)) u_src_bus (
        .mclk (mclk),
        .rst  (rst),
        .fl   (src_bus.owner)
    );

    ufhis_flags #(.W(8)) u_src_ctrl (
        .mclk (mclk),
        .rst  (rst),
        .fl   (src_ctrl.owner)
    );

    // Bit 5 of the first register and bit 7 of the second are reserved and read as zero.
    wire ufhis_byte_t src_bus_v  = src_bus.q & 8'hdf;
    wire ufhis_byte_t src_ctrl_v = src_ctrl.q & 8'h7f;
    logic [15:0]      src_prev;
    wire logic        src_changed = ({src_bus_v, src_ctrl_v} != src_prev);

    // Remaining state.
    logic               suspended;
    logic               arm_clr_pend;
    logic [DMA_EPS-1:0] dma_en;
    logic [DMA_EPS-1:0] dma_done;

    wire logic next_suspended = (resume_suspend_evt && bus_suspended) ||
                                (suspended && !rd_stat1 && !resume_suspend_evt);
    wire logic next_arm_pend  = (arm_clr_pend && !ctrl_tx_fifo_cleared) ||
                                (status_enter_no_ack && fw_read_xfer);
    wire logic arm_clr_fire   = arm_clr_pend && ctrl_tx_fifo_cleared;
    wire logic next_rx_pres   = (ctrl_rx_present && !ctrl_rx_drained) || rx_data_ep0;

    // A terminal count beats a firmware enable written in the same cycle.
    wire logic [DMA_EPS-1:0] next_dma_en   = (wr_dma_en ? wdata[DMA_EPS-1:0] : dma_en) &
                                             ~tc_edge;
    wire logic [DMA_EPS-1:0] next_dma_done = (rd_dma_done ? '0 : dma_done) | tc_edge;

    wire ufhis_byte_t setup_byte = setup_packet_buffer[{setup_cnt, 3'h0} +: 8];
    wire ufhis_byte_t next_rdata =
        !rd           ? `UFHIS_RST_BYTE :
        sel_src_bus   ? src_bus_v :
        sel_src_ctrl  ? src_ctrl_v :
        sel_stat0     ? {7'h00, ctrl_rx_present} :
        sel_stat1     ? {suspended, 7'h00} :
        sel_halt      ? {1'b0, endpoint_halt_flags} :
        sel_halt_set  ? {1'b0, halt_feat} :
        sel_dma_en    ? ufhis_byte_t'(dma_en) :
        sel_dma_done  ? ufhis_byte_t'(dma_done) :
        sel_setup     ? setup_byte :
                        `UFHIS_RST_BYTE;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            halt_cond           <= 7'h00;
            halt_feat           <= 7'h00;
            ep0_mask            <= 1'b0;
            send_stall_flag     <= 1'b0;
            endpoint_halt_flags <= 7'h00;
            stall_handshake     <= 1'b0;
        end else begin
            halt_cond           <= next_halt_cond;
            halt_feat           <= next_halt_feat;
            ep0_mask            <= next_ep0_mask;
            send_stall_flag     <= next_snd_stall;
            endpoint_halt_flags <= next_halted;
            stall_handshake     <= reconf_stalled;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            src_prev         <= 16'h0000;
            usb_irq_line_a_n <= 1'b1;
            suspended        <= 1'b0;
            arm_clr_pend     <= 1'b0;
            ctrl_tx_arm_clear <= 1'b0;
            ctrl_rx_present  <= 1'b0;
        end else begin
            src_prev         <= {src_bus_v, src_ctrl_v};
            usb_irq_line_a_n <= !src_changed;
            suspended        <= next_suspended;
            arm_clr_pend     <= next_arm_pend;
            ctrl_tx_arm_clear <= arm_clr_fire;
            ctrl_rx_present  <= next_rx_pres;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tc_prev_n <= {DMA_EPS{1'b1}};
            dma_en    <= '0;
            dma_done  <= '0;
            dma_req   <= '0;
            setup_cnt <= 3'h0;
            rdata     <= `UFHIS_RST_BYTE;
        end else begin
            tc_prev_n <= tc_s_n;
            dma_en    <= next_dma_en;
            dma_done  <= next_dma_done;
            dma_req   <= next_dma_en & dma_fifo_ready;
            setup_cnt <= setup_stored ? 3'h0 : setup_cnt + (rd_setup ? 3'h1 : 3'h0);
            rdata     <= next_rdata;
        end
    end

    // Checks.
    sequence s_stall_then_setup;
        send_stall_flag && setup_token && !stall_ep[0];
    endsequence

    sequence s_reconf_blocked;
        reconf_stalled && !wr_halt_clr && !rq_clr_ep;
    endsequence

    a_halt_on_stall: assert property (@(posedge mclk) disable iff (rst)
        (stall_ep != 7'h00) |=> ((halt_cond & $past(stall_ep)) == $past(stall_ep)))
        else $error("stall did not set halted bit");

    a_setup_ends_stall: assert property (@(posedge mclk) disable iff (rst)
        s_stall_then_setup |=> !send_stall_flag && !halt_cond[0])
        else $error("setup did not clear send stall");

    a_ep0_feat_holds: assert property (@(posedge mclk) disable iff (rst)
        halt_feat[0] && !(rq_clr_ep && req_ep == 3'h0) && !(wr_halt_clr && wdata[0])
        |=> halt_feat[0])
        else $error("endpoint 0 feature halt lost");

    a_ep0_masked: assert property (@(posedge mclk) disable iff (rst)
        (rq_get0 || rq_fw_dec) ##1 !setup_token[*2] |=> !endpoint_halt_flags[0])
        else $error("endpoint 0 halt not masked");

    a_reconf_clears: assert property (@(posedge mclk) disable iff (rst)
        reconf_ok && !wr_halt_set && !rq_set_ep
        |=> (halt_feat[6:1] & $past(req_targets[6:1])) == 6'h00)
        else $error("reconfiguration left a halt");

    a_ep0_stall_resp: assert property (@(posedge mclk) disable iff (rst)
        s_reconf_blocked |=> stall_handshake && halt_feat[0] == $past(halt_feat[0]))
        else $error("blocked reconfiguration mishandled");

    a_irq_on_change: assert property (@(posedge mclk) disable iff (rst)
        $changed({src_bus_v, src_ctrl_v}) |=> !usb_irq_line_a_n)
        else $error("source change raised no interrupt");

    a_clear_by_zero: assert property (@(posedge mclk) disable iff (rst)
        wr_clr_bus && !wdata[`UFHIS_B_BUS_RESET] && !bus_reset_det
        |=> !src_bus.q[`UFHIS_B_BUS_RESET])
        else $error("zero write did not clear bit");

    a_dma_end_stop: assert property (@(posedge mclk) disable iff (rst)
        (tc_edge != '0) |=> src_bus.q[`UFHIS_B_DMA_END] && ((dma_req & $past(tc_edge)) == '0))
        else $error("dma request not stopped at terminal count");

    a_setup_clr_stage: assert property (@(posedge mclk) disable iff (rst)
        setup_token && !status_done && !status_enter && !status_enter_no_ack
        |=> !src_ctrl.q[`UFHIS_B_STAT_OK] && !src_ctrl.q[`UFHIS_B_STAT_PHASE])
        else $error("setup left status stage bits");
endmodule

// ---- tb/ufhis_host.sv ----
// Host-side model: each commanded bus event leaves as a one-cycle pulse.
module ufhis_host (
    // Clock, reset, event requests and pulses
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [22:0] cmd,
    output logic      [22:0] ev
);
    timeunit 1ns / 1ns;
    always_ff @(posedge mclk or posedge rst) ev <= rst ? '0 : cmd;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the endpoint halt and interrupt source block.
module testbench;
    timeunit 1ns / 1ns;
    import ufhis_pkg::*;
    logic        mclk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, irq_d = 1, irq_n, stall;
    logic [31:0] addr = '0;
    logic [22:0] cmd = '0, ev;
    logic [63:0] setup_buf;
    logic [5:0]  tc_n = '1, dma_req;
    logic [1:0]  full = '0, sp_n = '1;
    ufhis_byte_t wdata = '0, rdata, exp_q[$];
    ufhis_ep_t   req_targets = 7'h7f, halt, m;
    int          num_errors = 0, compares = 0, nirq = 0, nhs = 0, narm = 0;
    logic        hs, arm, rx_pres, fwrd = 0, susp = 1;
    ufhis_req_t  kind = UFHIS_REQ_SET_CONFIG;
    ufhis_host i_host (.mclk, .rst, .cmd, .ev);
    ufhis_status i_dut (
        .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .bus_reset_det(ev[0]),
        .resume_suspend_evt(ev[1]), .bus_suspended(susp), .setup_token(ev[2]),
        .setup_stored(ev[3]), .setup_packet_buffer(setup_buf), .stall_ep(ev[20:14]),
        .req_valid(ev[4]), .req_kind(kind), .req_ep(3'h0), .req_targets,
        .in_nak_ep0(ev[5]), .tx_ack_ep0(ev[6]), .rx_data_ep0(ev[7]), .status_done(ev[8]),
        .status_enter(ev[9]), .status_enter_no_ack(ev[10]), .fw_read_xfer(fwrd),
        .ctrl_tx_fifo_write(ev[11]), .ctrl_tx_fifo_cleared(ev[12]), .ctrl_rx_drained(ev[13]),
        .bulk_read(ev[22:21]), .bulk_dma_full(full), .short_packet_signal_n(sp_n),
        .dma_tc_n(tc_n), .dma_fifo_ready(6'h3f), .dma_req, .usb_irq_line_a_n(irq_n),
        .endpoint_halt_flags(halt), .send_stall_flag(stall), .stall_handshake(hs),
        .ctrl_tx_arm_clear(arm), .ctrl_rx_present(rx_pres));
    initial forever #50 mclk = ~mclk;
    task cmp(string s, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) num_errors++;
        if (g !== e) $display("MISMATCH %s expected %h seen %h", s, e, g);
    endtask
    task automatic fire(logic [22:0] c, int k);
        int n = nirq; // Only pulses caused by this event count.
        cmd <= c;
        @(posedge mclk);
        cmd <= '0;
        repeat (5) @(posedge mclk);
        cmp("irq", 8'(k), 8'(nirq - n));
    endtask
    task acc(logic w, logic [31:0] a, ufhis_byte_t d);
        addr <= a;
        wdata <= d;
        {wr, rd} <= {w, !w};
        if (!w) exp_q.push_back(d);
        @(posedge mclk);
        {wr, rd} <= 2'b00;
        repeat (3) @(posedge mclk); // The monitor takes the answer before the next strobe.
    endtask
    always @(posedge mclk) begin
        if (rd_d) cmp("rdata", exp_q.pop_front(), rdata);
        if (irq_d === 1'b1 && irq_n === 1'b0) nirq++;
        if (hs === 1'b1) nhs++;
        if (arm === 1'b1) narm++;
        rd_d <= rd;
        irq_d <= irq_n;
    end
    task tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(86576));
        setup_buf = {$urandom, $urandom};
        m = 7'($urandom_range(127, 2)) | 7'h01;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        acc(0, 32'hfffffe3c, 8'h00);
        fire(23'h1, 1);
        fire(23'h2, 1);
        acc(0, 32'hfffffe08, 8'h80);
        acc(0, 32'hfffffe08, 8'h00);
        acc(1, 32'h0ffffe10, 8'h00);
        acc(1, 32'hfffffe0c, 8'h7f);
        acc(0, 32'h0ffffe10, 8'h40);
        fire({2'b00, m, 14'h0}, 1);
        cmp("halt", {1'b1, m}, {stall, halt});
        fire(23'h4, 0);
        cmp("halt", {1'b0, m & 7'h7e}, {stall, halt});
        fire(23'h10, 1);
        cmp("halt", 8'h00, {stall, halt});
        acc(0, 32'h0ffffe10, 8'h45);
        for (int i = 5; i < 10; i++) fire(23'(1 << i), 1);
        fire(23'h8, 1);
        acc(0, 32'hfffffe11, 8'h7e);
        cmp("rx present", 8'h01, {7'h00, rx_pres});
        fire(23'h4, 1);
        fire(23'h800, 1);
        fire(23'h2000, 1);
        acc(0, 32'h0ffffe07, 8'h00);
        acc(0, 32'hfffffe11, 8'h42);
        acc(1, 32'hfffffe0e, 8'h01);
        cmp("dma req", 8'h01, {2'b00, dma_req});
        {tc_n, full, sp_n} <= {6'h3e, 2'b01, 2'b10};
        repeat (6) @(posedge mclk); // Lets the synchronised pin edge land first.
        cmp("dma req", 8'h00, {2'b00, dma_req});
        fire(23'h200000, 1);
        acc(0, 32'h0ffffe10, 8'h5d);
        // A firmware halt on endpoint 0 must make a reconfiguration stall and clear nothing.
        acc(1, 32'hfffffe0a, 8'h03);
        fire(23'h10, 0);
        cmp("handshake", 8'h01, 8'(nhs));
        cmp("halt", 8'h03, {stall, halt});
        kind <= UFHIS_REQ_GET_STATUS_EP0;
        fire(23'h10, 0);
        cmp("halt", 8'h02, {stall, halt});
        fire(23'h4, 0);
        cmp("halt", 8'h03, {stall, halt});
        kind <= UFHIS_REQ_CLEAR_FEATURE_EP;
        fire(23'h10, 1);
        acc(0, 32'hfffffe0a, 8'h02);
        kind <= UFHIS_REQ_FW_DECODE;
        fire(23'h10, 1);
        for (int j = 0; j < 8; j++) acc(0, 32'hfffffe20, setup_buf[8*j +: 8]);
        acc(0, 32'hfffffe11, 8'h42);
        fwrd <= 1'b1;
        fire(23'h400, 1);
        fire(23'h1000, 0);
        cmp("arm clear", 8'h01, 8'(narm));
        fire(23'h2, 0);
        susp <= 1'b0;
        fire(23'h2, 0);
        acc(0, 32'hfffffe08, 8'h00);
        tally_and_finish();
    end
endmodule
